/* bench/mpbl_link_src.sv */
// link-side source model: sends 48-bit words as nibble frames on its own clock
// assumes the bench calls send_word and waits for it to return
`timescale 1ns/1ps
// ==========================================
// link source
module mpbl_link_src (
  output logic       link_clk,
  output logic [3:0] link_data
);
  initial begin
    link_clk  = 1'b0;
    link_data = 4'hA;
  end
  task automatic send_word(input logic [47:0] w);
    for (int i = 11; i >= 0; i--) begin
      link_data = w[i*4 +: 4];
      #10;
      link_clk = 1'b1;
      #52.5;
      link_clk = 1'b0;
      #31.25;
      // released line must not look like held data
      if (i == 0)
        link_data = ~w[3:0];
      #31.25;
    end
  endtask : send_word
endmodule : mpbl_link_src

/* bench/tb_multi_port_boot_loader.sv */
// bench for the boot loader: strap decode, link and host boot paths
// assumes mpbl_pkg and the link source model are compiled first
`timescale 1ns/1ps
module tb_multi_port_boot_loader
  import mpbl_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, mem_wr_ready = 1'b0;
  logic        ext_boot_select, link_boot_select, boot_memory_select, rti_exec;
  logic        host_bus_request, host_select, host_cfg_wr, host_cfg_width16, host_wr;
  logic        host_bus_grant, host_ready, ack_out, ack_oe, ack_keeper, link_clk;
  logic        spi_sclk, spi_mosi, spi_cs_n, mem_wr_valid, mem_wr_wide, core_idle;
  logic        link_rx_wide, ext_dma_done_irq, link_dma_done_irq, serial_dma_done_irq, link_overrun;
  logic [3:0]  link_data;
  logic [15:0] host_data, dma_count;
  logic [23:0] mem_wr_addr, pc, dma_index;
  logic [31:0] ext_dma_control, serial_control_reg;
  logic [47:0] mem_wr_data;
  mpbl_mode_e  boot_mode;
  int          num_errors = 0, checks = 0, wcnt = 0, cyc = 0;
  logic [47:0] exp_q[$];
  logic [31:0] ser_w = 32'hC3A5F00F;

  mpbl_boot_loader DUT (.clk, .rst, .ext_boot_select, .link_boot_select, .boot_memory_select,
    .host_bus_request, .host_select, .host_cfg_wr, .host_cfg_width16, .host_wr, .host_data,
    .host_bus_grant, .host_ready, .ack_out, .ack_oe, .ack_keeper, .link_clk, .link_data,
    .spi_sclk, .spi_mosi, .spi_cs_n, .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data,
    .mem_wr_wide, .rti_exec, .boot_mode, .core_idle, .pc, .ext_dma_control, .serial_control_reg,
    .link_rx_wide, .dma_count, .dma_index, .ext_dma_done_irq, .link_dma_done_irq,
    .serial_dma_done_irq, .link_overrun);
  mpbl_link_src SRC (.link_clk, .link_data);

  always #2.5 clk = ~clk;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // ==========================================
  // memory side with stalls, watchdog
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mem_wr_ready <= (cyc % 3) != 0;
    if (rst)
      wcnt <= 0;
    else if (mem_wr_valid && mem_wr_ready) begin
      chk(mem_wr_addr, BOOT_BASE + 24'(wcnt), "addr");
      chk(mem_wr_data, exp_q.pop_front(), "data");
      chk(mem_wr_wide, boot_mode != MODE_SPI, "wide");
      wcnt <= wcnt + 1;
    end
  end

  always @(posedge clk) begin
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic do_reset(input logic e, input logic l, input logic b);
    ext_boot_select <= e;
    link_boot_select <= l;
    boot_memory_select <= b;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({ack_out, ack_oe, ack_keeper}, 3'b101, "ack in reset");
    chk(pc, PC_BOOT_IDLE, "pc in reset");
    @(posedge clk);
    rst <= 1'b0;
    exp_q.delete();
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask : do_reset

  task automatic hwr(input logic [15:0] d);
    host_wr <= 1'b1;
    host_data <= d;
    for (int i = 0; i < 50; i++) begin
      @(negedge clk);
      if (host_ready === 1'b1)
        break;
    end
    @(posedge clk);
  endtask : hwr

  // ==========================================
  // tests
  initial begin
    {host_bus_request, host_select, host_cfg_wr, host_cfg_width16, host_wr, rti_exec} = '0;
    {ext_boot_select, link_boot_select, boot_memory_select} = '0;
    host_data = '0;
    {spi_sclk, spi_mosi, spi_cs_n} = 3'b001;
    do_reset(1'b0, 1'b0, 1'b0);
    chk(boot_mode, MODE_NONE, "no-boot mode");
    chk(pc, PC_NOBOOT, "no-boot pc");
    chk({ext_dma_control, serial_control_reg}, 64'h0, "no-boot ctl");
    $display("test noboot done");
    @(posedge clk);
    do_reset(1'b0, 1'b1, 1'b0);
    chk(boot_mode, MODE_SPI, "serial mode");
    chk(serial_control_reg, SPI_CTL_INIT, "serial ctl");
    chk({dma_count, dma_index}, {SPI_COUNT, BOOT_BASE}, "serial dma");
    chk({core_idle, pc}, {1'b1, PC_BOOT_IDLE}, "idle at boot");
    @(posedge clk);
    ext_boot_select <= 1'b1;
    repeat (20) @(posedge clk);
    chk(boot_mode, MODE_SPI, "mode held");
    // one 32-bit word from the master
    exp_q.push_back({16'h0000, ser_w});
    spi_cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int b = 31; b >= 0; b--) begin
      spi_mosi <= ser_w[b];
      repeat (4) @(posedge clk);
      spi_sclk <= 1'b1;
      repeat (4) @(posedge clk);
      spi_sclk <= 1'b0;
    end
    for (int i = 0; i < 50 && wcnt < 1; i++)
      @(negedge clk);
    chk({32'(wcnt), dma_count}, {32'h1, 16'h017F}, "serial word");
    @(posedge clk);
    spi_cs_n <= 1'b1;
    $display("test serial done");
    do_reset(1'b0, 1'b1, 1'b1);
    chk(boot_mode, MODE_LINK, "link mode");
    chk({link_rx_wide, dma_count, dma_index}, {1'b1, LINK_COUNT, BOOT_BASE}, "link init");
    exp_q.push_back(48'hFEDCBA987654);
    exp_q.push_back(48'h0123456789AB);
    SRC.send_word(48'hFEDCBA987654);
    SRC.send_word(48'h0123456789AB);
    for (int i = 0; i < 400 && wcnt < 2; i++)
      @(negedge clk);
    chk(wcnt, 2, "link words");
    chk({link_overrun, link_dma_done_irq, serial_dma_done_irq, dma_count}, {3'b000, 16'h00FE}, "link count");
    $display("test link done");
    @(posedge clk);
    do_reset(1'b0, 1'b0, 1'b1);
    chk(boot_mode, MODE_HOST, "host mode");
    chk({ext_dma_control, dma_count, dma_index}, {HOST_CTL_INIT, HOST_COUNT, BOOT_BASE}, "host init");
    chk({ext_dma_control[0], ext_dma_control[1], ext_dma_control[5], ext_dma_control[8:6]}, 6'h2D, "fields");
    @(posedge clk);
    host_bus_request <= 1'b1;
    host_select <= 1'b1;
    for (int i = 0; i < 50 && host_bus_grant !== 1'b1; i++)
      @(negedge clk);
    chk(host_bus_grant, 1'b1, "grant");
    @(negedge clk);
    chk(ack_oe, 1'b1, "ack drive");
    @(posedge clk);
    host_cfg_wr <= 1'b1;
    host_cfg_width16 <= 1'b1;
    @(posedge clk);
    host_cfg_wr <= 1'b0;
    for (int n = 0; n < 256; n++) begin
      exp_q.push_back({16'(n * 3 + 2), 16'(n * 3 + 1), 16'(n * 3)});
      for (int k = 0; k < 3; k++)
        hwr(16'(n * 3 + k));
    end
    host_wr <= 1'b0;
    for (int i = 0; i < 100 && ext_dma_done_irq !== 1'b1; i++)
      @(negedge clk);
    chk({ext_dma_done_irq, pc, dma_count}, {1'b1, PC_DONE_VEC, 16'h0}, "done");
    chk(wcnt, 256, "host words");
    @(posedge clk);
    rti_exec <= 1'b1;
    @(posedge clk);
    rti_exec <= 1'b0;
    @(negedge clk);
    chk(pc, PC_RESUME, "resume");
    $display("test host done");
    stop_test();
  end
endmodule : tb_multi_port_boot_loader

/* rtl/mpbl_boot_loader.sv */
// boot loader: mode decode, host/link/serial word assembly, boot dma
// assumes core-side memory write port and an rti strobe from the sequencer
`timescale 1ns/1ps
module mpbl_boot_loader
  import mpbl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ext_boot_select,
  input  wire logic        link_boot_select,
  input  wire logic        boot_memory_select,
  input  wire logic        host_bus_request,
  input  wire logic        host_select,
  input  wire logic        host_cfg_wr,
  input  wire logic        host_cfg_width16,
  input  wire logic        host_wr,
  input  wire logic [15:0] host_data,
  output logic             host_bus_grant,
  output logic             host_ready,
  output logic             ack_out,
  output logic             ack_oe,
  output logic             ack_keeper,
  input  wire logic        link_clk,
  input  wire logic [3:0]  link_data,
  input  wire logic        spi_sclk,
  input  wire logic        spi_mosi,
  input  wire logic        spi_cs_n,
  output logic             mem_wr_valid,
  input  wire logic        mem_wr_ready,
  output logic [23:0]      mem_wr_addr,
  output logic [47:0]      mem_wr_data,
  output logic             mem_wr_wide,
  input  wire logic        rti_exec,
  output mpbl_mode_e       boot_mode,
  output logic             core_idle,
  output logic [23:0]      pc,
  output logic [31:0]      ext_dma_control,
  output logic [31:0]      serial_control_reg,
  output logic             link_rx_wide,
  output logic [15:0]      dma_count,
  output logic [23:0]      dma_index,
  output logic             ext_dma_done_irq,
  output logic             link_dma_done_irq,
  output logic             serial_dma_done_irq,
  output logic             link_overrun
);
  localparam int BUF_W = ADDR_W + INSTR_W + 1;
  // chip select idles high, so its filter starts there
  localparam logic [PIN_N-1:0] PIN_IDLE = PIN_N'(1) << P_CSN;

  // ==========================================================
  // pin synchronisers
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_s1;
  logic [PIN_N-1:0] pin_s2;
  logic [PIN_N-1:0] pin_s3;
  logic [PIN_N-1:0] lvl;
  logic [PIN_N-1:0] next_lvl;

  assign pin_raw  = {spi_cs_n, spi_mosi, spi_sclk, link_data, link_clk,
                     boot_memory_select, link_boot_select, ext_boot_select};
  // level moves only when second and third stage agree
  assign next_lvl = (pin_s2 & ~(pin_s2 ^ pin_s3)) | (lvl & (pin_s2 ^ pin_s3));

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_s3 <= PIN_IDLE;
      lvl    <= PIN_IDLE;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      lvl    <= next_lvl;
    end
  end

  // ==========================================================
  // mode capture and sequencing
  mpbl_state_e state;
  logic [2:0]  strap_cnt;
  logic        pend_valid;
  logic [47:0] pend_data;
  logic        buf_ready;
  logic        buf_empty;
  logic        push;
  logic        load_done;
  logic        want_more;

  assign push      = pend_valid && buf_ready;
  assign load_done = (dma_count == COUNT_ZERO) && !pend_valid && buf_empty;
  assign want_more = (state == ST_LOAD) && (dma_count != COUNT_ZERO)
                     && !(pend_valid && dma_count == COUNT_ONE);
  assign core_idle = (state == ST_STRAP) || (state == ST_LOAD);

  always_ff @(posedge clk) begin
    if (rst) begin
      strap_cnt <= 3'h0;
    end else if (state == ST_STRAP) begin
      strap_cnt <= strap_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      boot_mode <= MODE_NONE;
    end else if (state == ST_STRAP && strap_cnt == STRAP_WAIT) begin
      case ({lvl[P_EXT_BOOT_SELECT], lvl[P_LINK_BOOT_SELECT], lvl[P_BMS]})
        3'h1:    boot_mode <= MODE_HOST;
        3'h3:    boot_mode <= MODE_LINK;
        3'h2:    boot_mode <= MODE_SPI;
        default: boot_mode <= MODE_NONE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_STRAP;
    end else begin
      case (state)
        ST_STRAP: begin
          if (strap_cnt == STRAP_WAIT) begin
            state <= (lvl[P_EXT_BOOT_SELECT] | lvl[P_LINK_BOOT_SELECT] | lvl[P_BMS]) ? ST_LOAD : ST_RUN;
          end
        end
        ST_LOAD: begin
          if (load_done) begin
            state <= ST_VECTOR;
          end
        end
        ST_VECTOR: begin
          if (rti_exec) begin
            state <= ST_RUN;
          end
        end
        ST_RUN:  state <= ST_RUN;
        default: state <= ST_STRAP;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc <= PC_BOOT_IDLE;
    end else if (state == ST_STRAP && strap_cnt == STRAP_WAIT
                 && !(lvl[P_EXT_BOOT_SELECT] | lvl[P_LINK_BOOT_SELECT] | lvl[P_BMS])) begin
      pc <= PC_NOBOOT;
    end else if (state == ST_LOAD && load_done) begin
      pc <= PC_DONE_VEC;
    end else if (state == ST_VECTOR && rti_exec) begin
      pc <= PC_RESUME;
    end
  end

  // completion interrupt, one pulse per boot
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_dma_done_irq    <= 1'b0;
      link_dma_done_irq   <= 1'b0;
      serial_dma_done_irq <= 1'b0;
    end else begin
      ext_dma_done_irq    <= (state == ST_LOAD) && load_done && (boot_mode == MODE_HOST);
      link_dma_done_irq   <= (state == ST_LOAD) && load_done && (boot_mode == MODE_LINK);
      serial_dma_done_irq <= (state == ST_LOAD) && load_done && (boot_mode == MODE_SPI);
    end
  end

  // ==========================================================
  // channel parameters
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_dma_control    <= CTL_DEFAULT;
      serial_control_reg <= CTL_DEFAULT;
      link_rx_wide       <= 1'b0;
      dma_count          <= COUNT_ZERO;
      dma_index          <= BOOT_BASE;
    end else if (state == ST_STRAP && strap_cnt == STRAP_WAIT) begin
      case ({lvl[P_EXT_BOOT_SELECT], lvl[P_LINK_BOOT_SELECT], lvl[P_BMS]})
        3'h1: begin
          ext_dma_control <= HOST_CTL_INIT;
          dma_count       <= HOST_COUNT;
        end
        3'h3: begin
          link_rx_wide <= 1'b1;
          dma_count    <= LINK_COUNT;
        end
        3'h2: begin
          serial_control_reg <= SPI_CTL_INIT;
          dma_count          <= SPI_COUNT;
        end
        default: dma_count <= COUNT_ZERO;
      endcase
    end else if (push) begin
      dma_count <= dma_count - COUNT_ONE;
      dma_index <= dma_index + INDEX_STEP;
    end
  end

  // ==========================================================
  // host packing, external buffer zero
  logic        host_w16;
  logic [2:0]  host_cnt;
  logic [47:0] host_word;
  logic        host_take;
  logic        host_last;

  assign host_bus_grant = (boot_mode == MODE_HOST) && (state == ST_LOAD)
                          && host_bus_request && host_select;
  assign host_ready     = host_bus_grant && want_more && !pend_valid
                          && ext_dma_control[DEN_BIT];
  assign host_take      = host_ready && host_wr && !host_cfg_wr;
  assign host_last      = host_w16 ? (host_cnt == HALVES_LAST) : (host_cnt == BYTES_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      host_w16 <= 1'b0;
    end else if (host_bus_grant && host_cfg_wr) begin
      host_w16 <= host_cfg_width16;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      host_cnt  <= 3'h0;
      host_word <= '0;
    end else if (host_take) begin
      host_cnt <= host_last ? 3'h0 : host_cnt + 3'h1;
      if (host_w16) begin
        host_word <= {host_data, host_word[47:16]};
      end else begin
        host_word <= {host_data[7:0], host_word[47:8]};
      end
    end
  end

  // keeper holds acknowledge high through reset
  assign ack_keeper = 1'b1;
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_out <= 1'b1;
      ack_oe  <= 1'b0;
    end else begin
      ack_out <= host_ready;
      ack_oe  <= host_bus_grant;
    end
  end

  // ==========================================================
  // link buffer zero, nibble capture
  logic        link_fall;
  logic [3:0]  link_cnt;
  logic [47:0] link_word;
  logic        link_take;

  assign link_fall = lvl[P_LCLK] && !next_lvl[P_LCLK];
  // only buffer zero, only in link mode
  assign link_take = link_fall && (boot_mode == MODE_LINK) && want_more;

  always_ff @(posedge clk) begin
    if (rst) begin
      link_cnt  <= 4'h0;
      link_word <= '0;
    end else if (link_take) begin
      link_cnt  <= (link_cnt == NIBS_LAST) ? 4'h0 : link_cnt + 4'h1;
      link_word <= {link_word[43:0], next_lvl[P_LDAT +: 4]};
    end
  end

  // ==========================================================
  // serial receive shifter
  logic        sclk_rise;
  logic [5:0]  ser_cnt;
  logic [31:0] ser_shift;
  logic        ser_take;

  assign sclk_rise = !lvl[P_SCLK] && next_lvl[P_SCLK];
  assign ser_take  = sclk_rise && !lvl[P_CSN] && (boot_mode == MODE_SPI) && want_more;

  // 32 bits per transfer whatever the master's word size
  always_ff @(posedge clk) begin
    if (rst) begin
      ser_cnt   <= 6'h0;
      ser_shift <= '0;
    end else if (ser_take) begin
      ser_cnt   <= (ser_cnt == BITS_LAST) ? 6'h0 : ser_cnt + 6'h1;
      ser_shift <= {ser_shift[30:0], next_lvl[P_MOSI]};
    end
  end

  // ==========================================================
  // pending word and buffer
  logic host_done;
  logic link_done;
  logic ser_done;

  assign host_done = host_take && host_last;
  assign link_done = link_take && (link_cnt == NIBS_LAST);
  assign ser_done  = ser_take && (ser_cnt == BITS_LAST);

  // new completion wins over the push
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_valid <= 1'b0;
      pend_data  <= '0;
    end else if (host_done) begin
      pend_valid <= 1'b1;
      pend_data  <= host_w16 ? {host_data, host_word[47:16]} : {host_data[7:0], host_word[47:8]};
    end else if (link_done) begin
      pend_valid <= 1'b1;
      pend_data  <= {link_word[43:0], next_lvl[P_LDAT +: 4]};
    end else if (ser_done) begin
      pend_valid <= 1'b1;
      pend_data  <= {16'h0000, ser_shift[30:0], next_lvl[P_MOSI]};
    end else if (push) begin
      pend_valid <= 1'b0;
    end
  end

  // word lost when the link or serial receiver outruns a stalled memory
  always_ff @(posedge clk) begin
    if (rst) begin
      link_overrun <= 1'b0;
    end else if ((link_done || ser_done) && pend_valid && !push) begin
      link_overrun <= 1'b1;
    end
  end

  logic [BUF_W-1:0] buf_out;

  // serial words land as 32-bit normal words
  mpbl_fifo2 #(.W(BUF_W)) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (pend_valid),
    .in_ready  (buf_ready),
    .in_data   ({dma_index, pend_data, (boot_mode != MODE_SPI)}),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready),
    .out_data  (buf_out),
    .empty     (buf_empty)
  );

  assign mem_wr_addr = buf_out[BUF_W-1 -: ADDR_W];
  assign mem_wr_data = buf_out[INSTR_W:1];
  assign mem_wr_wide = buf_out[0];

  // ==========================================================
  // checks
  sequence load_finish_s;
    (state == ST_LOAD) && load_done;
  endsequence

  mode_latch_held_a: assert property (@(posedge clk) disable iff (rst)
    (state != ST_STRAP) |=> $stable(boot_mode)) else $error("boot mode changed after capture");

  host_ctl_image_a: assert property (@(posedge clk) disable iff (rst)
    (boot_mode == MODE_HOST && state == ST_LOAD) |-> (ext_dma_control == HOST_CTL_INIT))
    else $error("host control word wrong");

  pack_fields_a: assert property (@(posedge clk) disable iff (rst)
    (boot_mode == MODE_HOST && state != ST_STRAP) |-> (ext_dma_control[DEN_BIT]
      && !ext_dma_control[WORD_ORDER_FIELD_BIT] && ext_dma_control[COLUMN_TYPE_FIELD_BIT]
      && ext_dma_control[PACKING_FIELD_LSB +: 3] == PACKING_FIELD_PACK8)) else $error("host packing fields wrong");

  serial_ctl_a: assert property (@(posedge clk) disable iff (rst)
    (boot_mode == MODE_SPI && state != ST_STRAP) |-> (serial_control_reg == SPI_CTL_INIT))
    else $error("serial control word wrong");

  done_vector_a: assert property (@(posedge clk) disable iff (rst)
    load_finish_s |=> (pc == PC_DONE_VEC) && (state == ST_VECTOR)
      && (ext_dma_done_irq || link_dma_done_irq || serial_dma_done_irq))
    else $error("no vector after last transfer");

  irq_pulse_a: assert property (@(posedge clk) disable iff (rst)
    $rose(ext_dma_done_irq) |=> !ext_dma_done_irq [*3]) else $error("done interrupt repeated");

  resume_pc_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_VECTOR && rti_exec) |=> (pc == PC_RESUME) && (state == ST_RUN))
    else $error("rti did not resume at reset routine");

  count_step_a: assert property (@(posedge clk) disable iff (rst)
    (push && state == ST_LOAD) |=> (dma_count == $past(dma_count) - COUNT_ONE))
    else $error("count did not step per transfer");

  idle_pc_a: assert property (@(posedge clk) disable iff (rst)
    core_idle |-> (pc == PC_BOOT_IDLE)) else $error("pc moved during boot load");

  grant_mode_a: assert property (@(posedge clk) disable iff (rst)
    host_bus_grant |-> core_idle && (pc == PC_BOOT_IDLE))
    else $error("grant while core not idle in boot");

  ack_reset_a: assert property (@(posedge clk)
    rst |=> ack_out && !ack_oe) else $error("acknowledge not held high in reset");

  noboot_pc_a: assert property (@(posedge clk) disable iff (rst)
    (boot_mode == MODE_NONE && state == ST_RUN) |-> (pc == PC_NOBOOT) && (dma_count == COUNT_ZERO))
    else $error("no-boot fetch address wrong");

endmodule : mpbl_boot_loader

/* rtl/mpbl_fifo2.sv */
// two-entry buffer with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module mpbl_fifo2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic              empty
);
  logic [W-1:0] store [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   fill;
  logic         push;
  logic         pop;

  assign in_ready  = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign empty     = (fill == 2'h0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        fill <= fill + 2'h1;
      end else if (pop && !push) begin
        fill <= fill - 2'h1;
      end
    end
  end
endmodule : mpbl_fifo2

/* rtl/mpbl_pkg.sv */
// Functional notes
// - ext select low, link select low, memory select high at reset: host boot.
// - host boot waits passively as bus slave for the host's program.
// - host bytes or halfwords are packed into 48-bit words on channel 10.
// - host and link boot load 256 words into 0x40000 to 0x400FF first.
// - after reset the core idles with pc 0x40004 and does not execute it.
// - host boot: index 0x40000, count 0x0100, control 0x161.
// - host control enables port, LSB first, packing 101, three-column data.
// - count decrements per transfer; at zero stop, raise done, vector 0x40050.
// - return from interrupt at the done vector resumes at 0x40005.
// - acknowledge is kept high during reset by an internal keeper.
// - ext low, link high, memory select high at reset: link boot.
// - link boot receives nibbles into link buffer zero via channel 8.
// - source clocks the link; nibbles are captured on falling edges.
// - link boot: index 0x40000, count 0x0100, buffer zero takes 48-bit words.
// - link boot always uses buffer zero; parallel or chained boot allowed.
// - ext low, link high, memory select low at reset: serial boot.
// - serial boot loads serial control with 0x0A001F81, 32-bit receive.
// - serial boot moves 0x0180 32-bit words from 0x40000, then executes.
// - receive shifter gathers 32 bits (2x16 or 4x8) per transfer.
// - no-boot skips loading, keeps defaults, fetches from 0x200004.
// - all three selects low at reset: no-boot mode.
//
// constants shared by the boot loader files
// assumes a single 200 MHz core clock domain
package mpbl_pkg;

  localparam int          INSTR_W        = 48;
  localparam int          ADDR_W         = 24;
  localparam int          SER_W          = 32;
  localparam int          CNT_W          = 16;

  localparam logic [23:0] BOOT_BASE      = 24'h040000;
  localparam logic [23:0] PC_BOOT_IDLE   = 24'h040004;
  localparam logic [23:0] PC_DONE_VEC    = 24'h040050;
  localparam logic [23:0] PC_RESUME      = 24'h040005;
  localparam logic [23:0] PC_NOBOOT      = 24'h200004;

  localparam logic [15:0] HOST_COUNT     = 16'h0100;
  localparam logic [15:0] LINK_COUNT     = 16'h0100;
  localparam logic [15:0] SPI_COUNT      = 16'h0180;
  localparam logic [15:0] COUNT_ONE      = 16'h0001;
  localparam logic [15:0] COUNT_ZERO     = 16'h0000;
  localparam logic [23:0] INDEX_STEP     = 24'h000001;

  localparam logic [31:0] HOST_CTL_INIT  = 32'h00000161;
  localparam logic [31:0] SPI_CTL_INIT   = 32'h0A001F81;
  localparam logic [31:0] CTL_DEFAULT    = 32'h00000000;
  localparam int          DEN_BIT        = 0;
  localparam int          WORD_ORDER_FIELD_BIT       = 1;
  localparam int          COLUMN_TYPE_FIELD_BIT      = 5;
  localparam int          PACKING_FIELD_LSB      = 6;
  localparam logic [2:0]  PACKING_FIELD_PACK8    = 3'h5;

  localparam logic [2:0]  BYTES_LAST     = 3'h5;
  localparam logic [2:0]  HALVES_LAST    = 3'h2;
  localparam logic [3:0]  NIBS_LAST      = 4'hB;
  localparam logic [5:0]  BITS_LAST      = 6'h1F;
  localparam logic [2:0]  STRAP_WAIT     = 3'h5;

  // pin positions in the synchroniser vector
  localparam int          PIN_N          = 11;
  localparam int          P_EXT_BOOT_SELECT        = 0;
  localparam int          P_LINK_BOOT_SELECT        = 1;
  localparam int          P_BMS          = 2;
  localparam int          P_LCLK         = 3;
  localparam int          P_LDAT         = 4;
  localparam int          P_SCLK         = 8;
  localparam int          P_MOSI         = 9;
  localparam int          P_CSN          = 10;

  typedef enum logic [3:0] {
    MODE_NONE = 4'h1,
    MODE_HOST = 4'h2,
    MODE_LINK = 4'h4,
    MODE_SPI  = 4'h8
  } mpbl_mode_e;

  typedef enum logic [3:0] {
    ST_STRAP  = 4'h1,
    ST_LOAD   = 4'h2,
    ST_VECTOR = 4'h4,
    ST_RUN    = 4'h8
  } mpbl_state_e;

endpackage : mpbl_pkg
